// *** hdl/diag_params.svh ***
// Constants of the diagnostic comparison sequencer: register offsets, field positions,
// reset values and fixed figures. Assumes inclusion by bare name from hdl/.
`ifndef DIAG_PARAMS_SVH
`define DIAG_PARAMS_SVH

// ====================================================================
// Register offsets (8-bit registers, byte addressed)
`define OFS_CTRL          8'h00
`define OFS_STATUS        8'h01
`define OFS_TEST_FET_LO   8'h02
`define OFS_TEST_FET_HI   8'h03
`define OFS_FET_RES_LO    8'h04
`define OFS_FET_RES_HI    8'h05
`define OFS_VCOW_RES_LO   8'h06
`define OFS_VCOW_RES_HI   8'h07
`define OFS_CBOW_RES_LO   8'h08
`define OFS_CBOW_RES_HI   8'h09
`define OFS_OPEN_THR      8'h0a
`define OFS_BAL_CFG       8'h0b
`define OFS_BAL_EN_LO     8'h0c
`define OFS_BAL_EN_HI     8'h0d
`define OFS_ADC_CFG       8'h0e
`define OFS_AUX_SEL       8'h0f
`define OFS_CELL_CNT      8'h10
`define OFS_BB_POS_HI     8'h11
`define OFS_BB_POS_LO     8'h12
`define OFS_AUX_RES_HI    8'h13
`define OFS_AUX_RES_LO    8'h14
`define OFS_RPT_AUX_HI    8'h15
`define OFS_RPT_AUX_LO    8'h16
`define OFS_RPT_MAIN_HI   8'h17
`define OFS_RPT_MAIN_LO   8'h18

// ====================================================================
// Field positions
`define CTRL_SEL_LSB      0
`define CTRL_GO_BIT       3
`define CTRL_APPLY_BIT    4
`define CTRL_SNK_LSB      5
`define ST_FET_DONE       0
`define ST_AUX_DONE       1
`define ST_VCOW_DONE      2
`define ST_CBOW_DONE      3
`define ST_ABORTED        4
`define ST_BUSY           5
`define BAL_PAUSE_BIT     0
`define BAL_ENABLE_BIT    1
`define ADC_MAIN_ON       0
`define ADC_MAIN_CONT     1
`define ADC_AUX_ON        2
`define ADC_AUX_CONT      3

// ====================================================================
// Reset and forced values, fixed figures
`define AUX_RES_DEFAULT   16'h8000
`define RES_ABORT_VALUE   8'hff
`define CELL_CNT_DEFAULT  5'h10
`define AUX_SEL_LAST      5'h10
`define FET_MAX_ON        8
`define FET_MAX_RUN       2
`define BB_MAX_ON         2
`define BB_MAX_RUN        1

`endif

// *** hdl/diag_pkg.sv ***
// Types shared by the diagnostic comparison sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package diag_pkg;

  // Comparison kinds as written into the select field
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_VCOW = 3'h2,
    SEL_CBOW = 3'h3,
    SEL_FET  = 3'h4
  } comp_sel_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SCAN = 4'h2,
    ST_REQ  = 4'h4,
    ST_DONE = 4'h8
  } seq_state_t;

  typedef logic [15:0] chan_mask_t;

endpackage

`default_nettype wire

// *** hdl/pattern_check.sv ***
// Counts set bits of a channel pattern and finds its longest run of neighbours.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/1ps
`default_nettype none

module pattern_check #(
  parameter int W       = 16,
  parameter int MAX_ON  = 8,
  parameter int MAX_RUN = 2
) (
  input  wire logic [W-1:0] bits,
  output logic              too_many,
  output logic              run_too_long
);

  int cnt;
  int run;
  int best;

  always_comb begin
    cnt  = 0;
    run  = 0;
    best = 0;
    for (int i = 0; i < W; i++) begin
      if (bits[i]) begin
        cnt = cnt + 1;
        run = run + 1;
      end else begin
        run = 0;
      end
      if (run > best) begin
        best = run;
      end
    end
    too_many     = (cnt > MAX_ON);
    run_too_long = (best > MAX_RUN);
  end

endmodule // pattern_check

`default_nettype wire

// *** hdl/diag_compare.sv ***
// What this block does
// - Select code 0b100 plus go starts FET check
// - Enabled FETs: aux reading below half cell
// - FET check end sets fet_check_done
// - Unpausing restores balancing FETs, drops test FETs
// - Abort sets flags, forces FET results 0xff
// - Abort with locked channel resets aux result
// - Refuse invalid or out-of-range aux channel
// - Refuse invalid bus-bar positions
// - Refuse ADCs off/not continuous, unpaused balancing
// - Refuse over eight or three-in-row FETs
// - Sinks on all pins, sources on bottom pins
// - Sense check uses main, balance uses aux
// - Locked balance check reports aux value
// - Codes 0b010 and 0b011 start open-wire checks
// - Every active channel compared with threshold; locked balance check compares only the locked one
// - Open-wire end sets its done flag, results
//
// Diagnostic comparison sequencer with its register file, reached over a plain
// address/strobe port. ADC readings come from logic on the same clock.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "diag_params.svh"

module diag_compare (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata_r,
  output logic             sample_req_r,
  output logic      [3:0]  sample_ch_r,
  input  wire logic        sample_valid,
  input  wire logic [15:0] main_cell_reading,
  input  wire logic [15:0] aux_cell_reading,
  output logic      [15:0] fet_drive_r,
  output logic      [15:0] sense_sink_en_r,
  output logic             sense_source_en_r,
  output logic      [15:0] balance_sink_en_r,
  output logic             balance_source_en_r
);

  // ==================================================================
  // Register file storage
  logic [2:0]  sel_r;
  logic [1:0]  snk_r;
  logic [15:0] test_fet_r;
  logic [15:0] bal_mask_r;
  logic        pause_r;
  logic        bal_en_r;
  logic [3:0]  adc_cfg_r;
  logic [4:0]  aux_sel_r;
  logic [4:0]  cell_cnt_r;
  logic [15:0] bb_pos_r;
  logic [7:0]  thr_r;
  logic        fet_done_r;
  logic        aux_done_r;
  logic        vcow_done_r;
  logic        cbow_done_r;
  logic        abort_r;
  logic [15:0] fet_res_r;
  logic [15:0] vcow_res_r;
  logic [15:0] cbow_res_r;
  logic [15:0] aux_res_r;
  logic [15:0] diag_aux_r;

  // ==================================================================
  // Sequencer storage
  diag_pkg::seq_state_t state_r;
  diag_pkg::seq_state_t state_nxt;
  diag_pkg::comp_sel_t  mode_r;
  logic [4:0]  ch_r;

  // ==================================================================
  // Write decode
  wire wr_ctrl   = wr && (addr == `OFS_CTRL);
  wire wr_status = wr && (addr == `OFS_STATUS);
  wire wr_bal    = wr && (addr == `OFS_BAL_CFG);
  wire go_w      = wr_ctrl && wdata[`CTRL_GO_BIT];
  wire apply_w   = wr_ctrl && wdata[`CTRL_APPLY_BIT];
  wire resume_w  = wr_bal && !wdata[`BAL_PAUSE_BIT] && pause_r;
  wire idle      = (state_r == diag_pkg::ST_IDLE);
  wire [2:0] go_sel = wdata[`CTRL_SEL_LSB +: 3];

  wire start_fet  = go_w && idle && (go_sel == diag_pkg::SEL_FET);
  wire start_vcow = go_w && idle && (go_sel == diag_pkg::SEL_VCOW);
  wire start_cbow = go_w && idle && (go_sel == diag_pkg::SEL_CBOW);

  // ==================================================================
  // Launch checks for the FET comparison
  wire        aux_all    = (aux_sel_r == 5'h00);
  wire        aux_locked = (aux_sel_r != 5'h00) && (aux_sel_r <= `AUX_SEL_LAST);
  wire [3:0]  lock_ch    = 4'(aux_sel_r - 5'h01);
  wire        sel_bad    = (aux_sel_r > `AUX_SEL_LAST);
  wire        sel_high   = aux_locked && (aux_sel_r > cell_cnt_r);
  wire        fet_many;
  wire        fet_run;
  wire        bb_many;
  wire        bb_adj;

  pattern_check #(.W(16), .MAX_ON(`FET_MAX_ON), .MAX_RUN(`FET_MAX_RUN)) u_fet_pat (
    .bits         (test_fet_r),
    .too_many     (fet_many),
    .run_too_long (fet_run)
  );

  pattern_check #(.W(16), .MAX_ON(`BB_MAX_ON), .MAX_RUN(`BB_MAX_RUN)) u_bb_pat (
    .bits         (bb_pos_r),
    .too_many     (bb_many),
    .run_too_long (bb_adj)
  );

  // Bottom cell may not carry a bus bar, nor may the locked aux channel
  wire bb_bad   = bb_many || bb_adj || bb_pos_r[0] ||
                  (aux_locked && bb_pos_r[lock_ch]);
  wire adc_bad  = !(adc_cfg_r[`ADC_MAIN_ON] && adc_cfg_r[`ADC_MAIN_CONT] &&
                    adc_cfg_r[`ADC_AUX_ON] && adc_cfg_r[`ADC_AUX_CONT]);
  wire bal_bad  = bal_en_r && !pause_r;
  wire fet_bad  = fet_many || fet_run;
  wire abort_w  = start_fet &&
                  (sel_bad || sel_high || bb_bad || adc_bad || bal_bad || fet_bad);
  wire run_fet  = start_fet && !abort_w;
  wire launch   = run_fet || start_vcow || start_cbow;

  // ==================================================================
  // Channel selection and comparison
  wire [3:0] ch4     = ch_r[3:0];
  wire       ch_end  = (ch_r >= cell_cnt_r) || ch_r[4];
  wire       aux_hit = aux_all || (aux_locked && (lock_ch == ch4));
  wire       incl    = (mode_r == diag_pkg::SEL_FET)  ? (test_fet_r[ch4] && aux_hit) :
                       (mode_r == diag_pkg::SEL_CBOW) ? aux_hit : 1'b1;
  wire [15:0] thr16    = {thr_r, 8'h00};
  wire        fet_fail = !(aux_cell_reading < {1'b0, main_cell_reading[15:1]});
  wire        vc_fail  = (main_cell_reading < thr16);
  wire        cb_fail  = (aux_cell_reading < thr16);
  wire        take     = (state_r == diag_pkg::ST_REQ) && sample_valid;
  wire        done_w   = (state_r == diag_pkg::ST_DONE);
  wire        report   = take && aux_locked && (mode_r != diag_pkg::SEL_VCOW);
  wire [15:0] ch_bit   = 16'h0001 << ch4;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      diag_pkg::ST_IDLE: begin
        if (launch) begin
          state_nxt = diag_pkg::ST_SCAN;
        end
      end
      diag_pkg::ST_SCAN: begin
        if (ch_end) begin
          state_nxt = diag_pkg::ST_DONE;
        end else if (incl) begin
          state_nxt = diag_pkg::ST_REQ;
        end
      end
      diag_pkg::ST_REQ: begin
        if (sample_valid) begin
          state_nxt = diag_pkg::ST_SCAN;
        end
      end
      diag_pkg::ST_DONE: begin
        state_nxt = diag_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = diag_pkg::ST_IDLE;
      end
    endcase
  end

  // ==================================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r      <= diag_pkg::ST_IDLE;
      mode_r       <= diag_pkg::SEL_NONE;
      ch_r         <= 5'h00;
      sample_req_r <= 1'b0;
      sample_ch_r  <= 4'h0;
    end else if (ce) begin
      state_r      <= state_nxt;
      sample_req_r <= (state_nxt == diag_pkg::ST_REQ);
      sample_ch_r  <= ch4;
      if (launch) begin
        mode_r <= diag_pkg::comp_sel_t'(go_sel);
        ch_r   <= 5'h00;
      end else if (take || ((state_r == diag_pkg::ST_SCAN) && !ch_end && !incl)) begin
        ch_r <= ch_r + 5'h01;
      end
    end
  end

  // ==================================================================
  // Results; aborts force all-fail so a stale pass cannot be read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fet_res_r  <= 16'h0000;
      vcow_res_r <= 16'h0000;
      cbow_res_r <= 16'h0000;
      aux_res_r  <= `AUX_RES_DEFAULT;
      diag_aux_r <= 16'h0000;
    end else if (ce) begin
      if (abort_w) begin
        fet_res_r <= {`RES_ABORT_VALUE, `RES_ABORT_VALUE};
      end else if (run_fet) begin
        fet_res_r <= 16'h0000;
      end else if (take && (mode_r == diag_pkg::SEL_FET) && fet_fail) begin
        fet_res_r <= fet_res_r | ch_bit;
      end
      if (start_vcow) begin
        vcow_res_r <= 16'h0000;
      end else if (take && (mode_r == diag_pkg::SEL_VCOW) && vc_fail) begin
        vcow_res_r <= vcow_res_r | ch_bit;
      end
      if (start_cbow) begin
        cbow_res_r <= 16'h0000;
      end else if (take && (mode_r == diag_pkg::SEL_CBOW) && cb_fail) begin
        cbow_res_r <= cbow_res_r | ch_bit;
      end
      if (abort_w && aux_locked) begin
        aux_res_r <= `AUX_RES_DEFAULT;
      end else if (report) begin
        aux_res_r <= aux_cell_reading;
      end
      if (report) begin
        diag_aux_r <= aux_cell_reading;
      end
    end
  end

  // ==================================================================
  // Status flags: hardware set wins over a write-one clear
  wire [7:0] clr = wr_status ? wdata : 8'h00;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fet_done_r  <= 1'b0;
      aux_done_r  <= 1'b0;
      vcow_done_r <= 1'b0;
      cbow_done_r <= 1'b0;
      abort_r     <= 1'b0;
    end else if (ce) begin
      fet_done_r  <= abort_w || (done_w && (mode_r == diag_pkg::SEL_FET)) ||
                     (fet_done_r && !clr[`ST_FET_DONE]);
      aux_done_r  <= abort_w || (aux_done_r && !clr[`ST_AUX_DONE]);
      vcow_done_r <= (done_w && (mode_r == diag_pkg::SEL_VCOW)) ||
                     (vcow_done_r && !clr[`ST_VCOW_DONE]);
      cbow_done_r <= (done_w && (mode_r == diag_pkg::SEL_CBOW)) ||
                     (cbow_done_r && !clr[`ST_CBOW_DONE]);
      abort_r     <= abort_w || (abort_r && !clr[`ST_ABORTED]);
    end
  end

  // ==================================================================
  // Configuration registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_r      <= 3'h0;
      snk_r      <= 2'h0;
      test_fet_r <= 16'h0000;
      bal_mask_r <= 16'h0000;
      pause_r    <= 1'b0;
      bal_en_r   <= 1'b0;
      adc_cfg_r  <= 4'h0;
      aux_sel_r  <= 5'h00;
      cell_cnt_r <= `CELL_CNT_DEFAULT;
      bb_pos_r   <= 16'h0000;
      thr_r      <= 8'h00;
    end else if (ce && wr) begin
      unique case (addr)
        `OFS_CTRL: begin
          sel_r <= wdata[`CTRL_SEL_LSB +: 3];
          snk_r <= wdata[`CTRL_SNK_LSB +: 2];
        end
        `OFS_TEST_FET_LO: test_fet_r[7:0]  <= wdata;
        `OFS_TEST_FET_HI: test_fet_r[15:8] <= wdata;
        `OFS_BAL_EN_LO:   bal_mask_r[7:0]  <= wdata;
        `OFS_BAL_EN_HI:   bal_mask_r[15:8] <= wdata;
        `OFS_BAL_CFG: begin
          pause_r  <= wdata[`BAL_PAUSE_BIT];
          bal_en_r <= wdata[`BAL_ENABLE_BIT];
        end
        `OFS_ADC_CFG:  adc_cfg_r  <= wdata[3:0];
        `OFS_AUX_SEL:  aux_sel_r  <= wdata[4:0];
        `OFS_CELL_CNT: cell_cnt_r <= wdata[4:0];
        `OFS_BB_POS_LO: bb_pos_r[7:0]  <= wdata;
        `OFS_BB_POS_HI: bb_pos_r[15:8] <= wdata;
        `OFS_OPEN_THR: thr_r <= wdata;
        default: begin
        end
      endcase
    end
  end

  // ==================================================================
  // Balancing FET drive and open-wire current control
  wire bal_run = bal_en_r && !pause_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fet_drive_r         <= 16'h0000;
      sense_sink_en_r     <= 16'h0000;
      sense_source_en_r   <= 1'b0;
      balance_sink_en_r   <= 16'h0000;
      balance_source_en_r <= 1'b0;
    end else if (ce) begin
      if (apply_w) begin
        fet_drive_r <= test_fet_r;
      end else if (resume_w) begin
        fet_drive_r <= wdata[`BAL_ENABLE_BIT] ? bal_mask_r : 16'h0000;
      end else if (bal_run) begin
        fet_drive_r <= bal_mask_r;
      end
      // Code 01 drives the sense pins, 10 the balance pins, others nothing
      sense_sink_en_r     <= {16{snk_r == 2'h1}};
      sense_source_en_r   <= (snk_r == 2'h1);
      balance_sink_en_r   <= {16{snk_r == 2'h2}};
      balance_source_en_r <= (snk_r == 2'h2);
    end
  end

  // ==================================================================
  // Read path; unmapped offsets read zero
  wire [7:0] status_v = {2'b00, !idle, abort_r, cbow_done_r, vcow_done_r,
                         aux_done_r, fet_done_r};
  logic [7:0] rd_mux;

  always_comb begin
    unique case (addr)
      `OFS_CTRL:        rd_mux = {1'b0, snk_r, 2'b00, sel_r};
      `OFS_STATUS:      rd_mux = status_v;
      `OFS_TEST_FET_LO: rd_mux = test_fet_r[7:0];
      `OFS_TEST_FET_HI: rd_mux = test_fet_r[15:8];
      `OFS_FET_RES_LO:  rd_mux = fet_res_r[7:0];
      `OFS_FET_RES_HI:  rd_mux = fet_res_r[15:8];
      `OFS_VCOW_RES_LO: rd_mux = vcow_res_r[7:0];
      `OFS_VCOW_RES_HI: rd_mux = vcow_res_r[15:8];
      `OFS_CBOW_RES_LO: rd_mux = cbow_res_r[7:0];
      `OFS_CBOW_RES_HI: rd_mux = cbow_res_r[15:8];
      `OFS_OPEN_THR:    rd_mux = thr_r;
      `OFS_BAL_CFG:     rd_mux = {6'h00, bal_en_r, pause_r};
      `OFS_BAL_EN_LO:   rd_mux = bal_mask_r[7:0];
      `OFS_BAL_EN_HI:   rd_mux = bal_mask_r[15:8];
      `OFS_ADC_CFG:     rd_mux = {4'h0, adc_cfg_r};
      `OFS_AUX_SEL:     rd_mux = {3'h0, aux_sel_r};
      `OFS_CELL_CNT:    rd_mux = {3'h0, cell_cnt_r};
      `OFS_BB_POS_HI:   rd_mux = bb_pos_r[15:8];
      `OFS_BB_POS_LO:   rd_mux = bb_pos_r[7:0];
      `OFS_AUX_RES_HI:  rd_mux = aux_res_r[15:8];
      `OFS_AUX_RES_LO:  rd_mux = aux_res_r[7:0];
      `OFS_RPT_AUX_HI:  rd_mux = diag_aux_r[15:8];
      `OFS_RPT_AUX_LO:  rd_mux = diag_aux_r[7:0];
      // Main ADC has no single-channel lock, so nothing is reported here
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= rd ? rd_mux : 8'h00;
    end
  end

endmodule // diag_compare

`default_nettype wire

// *** dv/diag_compare_chk.sv ***
// Port-level checker for the diagnostic comparison sequencer.
// Assumes one clock domain, clk, with the synchronous active-low reset rstn.
`timescale 1ns/1ps
`default_nettype none

module diag_compare_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata_r,
  input wire logic        sample_req_r,
  input wire logic [3:0]  sample_ch_r,
  input wire logic        sample_valid,
  input wire logic [15:0] main_cell_reading,
  input wire logic [15:0] aux_cell_reading,
  input wire logic [15:0] fet_drive_r,
  input wire logic [15:0] sense_sink_en_r,
  input wire logic        sense_source_en_r,
  input wire logic [15:0] balance_sink_en_r,
  input wire logic        balance_source_en_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  wire ctrl_wr = ce && wr && (addr == 8'h00);
  wire sense_on = (sense_sink_en_r == 16'hffff) && sense_source_en_r;
  wire bal_on = (balance_sink_en_r == 16'hffff) && balance_source_en_r;
  wire sense_off = (sense_sink_en_r == 16'h0000) && !sense_source_en_r;
  wire bal_off = (balance_sink_en_r == 16'h0000) && !balance_source_en_r;

  // ====================================================================
  // Current sink and source control
  property p_sink_sense;
    ctrl_wr && (wdata[6:5] == 2'b01) |=> ##1 sense_on && bal_off;
  endproperty
  a_sink_sense: assert property (p_sink_sense) else $error("sense sinks wrong");
  property p_sink_bal;
    ctrl_wr && (wdata[6:5] == 2'b10) |=> ##1 bal_on && sense_off;
  endproperty
  a_sink_bal: assert property (p_sink_bal) else $error("balance sinks wrong");
  property p_sink_off;
    ctrl_wr && (wdata[6] == wdata[5]) |=> ##1 sense_off && bal_off;
  endproperty
  a_sink_off: assert property (p_sink_off) else $error("sinks not off");
  // Sense sinks move only because software asked; a drifting enable would fake an open wire
  property p_sink_hold;
    $changed(sense_sink_en_r) && $past(rstn) |-> $past(ctrl_wr, 2);
  endproperty
  a_sink_hold: assert property (p_sink_hold) else $error("sink moved alone");

  // ====================================================================
  // Sample handshake, FET drive, read port
  property p_req_hold;
    sample_req_r && !sample_valid && ce |=> sample_req_r && $stable(sample_ch_r);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_req_drop;
    sample_req_r && sample_valid && ce |=> !sample_req_r;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held");
  property p_fet_cause;
    $changed(fet_drive_r) && $past(rstn) |-> $past(wr) || $past(wr, 2);
  endproperty
  a_fet_cause: assert property (p_fet_cause) else $error("fet drive moved alone");
  property p_rdata_idle;
    ce && !rd |=> rdata_r == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule // diag_compare_chk

bind diag_compare diag_compare_chk i_diag_compare_chk (
  .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_r(rdata_r), .sample_req_r(sample_req_r), .sample_ch_r(sample_ch_r),
  .sample_valid(sample_valid), .main_cell_reading(main_cell_reading),
  .aux_cell_reading(aux_cell_reading), .fet_drive_r(fet_drive_r),
  .sense_sink_en_r(sense_sink_en_r), .sense_source_en_r(sense_source_en_r),
  .balance_sink_en_r(balance_sink_en_r), .balance_source_en_r(balance_source_en_r)
);

`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for diag_compare; the bench also answers sample requests.
// Assumes the checker file is compiled beside it.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk, rstn, ce, wr, rd, sample_valid;
  logic [7:0]  addr, wdata;
  logic [15:0] main_cell_reading, aux_cell_reading;
  wire  [7:0]  rdata_r;
  wire         sample_req_r, sense_source_en_r, balance_source_en_r;
  wire  [3:0]  sample_ch_r;
  wire  [15:0] fet_drive_r, sense_sink_en_r, balance_sink_en_r;
  logic [15:0] main_v [16];
  logic [15:0] aux_v  [16];
  int          mismatches, comparisons, nsamp, n0;
  // Good setup: ADCs on, paused, all channels, four cells, bus bar on cell 3
  logic [7:0] base_a [8] = '{8'h0e, 8'h0b, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h02, 8'h03};
  logic [7:0] base_d [8] = '{8'h0f, 8'h01, 8'h00, 8'h04, 8'h00, 8'h04, 8'h25, 8'h00};
  // One bad setting each; the locked-on-bus-bar case comes first
  logic [7:0] bad_a [11] = '{8'h0f, 8'h0e, 8'h0e, 8'h0b, 8'h02, 8'h03, 8'h0f, 8'h0f,
                             8'h12, 8'h12, 8'h12};
  logic [7:0] bad_d [11] = '{8'h03, 8'h07, 8'h0d, 8'h02, 8'h07, 8'hdb, 8'h11, 8'h05,
                             8'h06, 8'h05, 8'h15};

  diag_compare i_diag_compare (
    .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .sample_req_r(sample_req_r), .sample_ch_r(sample_ch_r),
    .sample_valid(sample_valid), .main_cell_reading(main_cell_reading),
    .aux_cell_reading(aux_cell_reading), .fet_drive_r(fet_drive_r),
    .sense_sink_en_r(sense_sink_en_r), .sense_source_en_r(sense_source_en_r),
    .balance_sink_en_r(balance_sink_en_r), .balance_source_en_r(balance_source_en_r)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ====================================================================
  // Reading source: answers one cycle after a request, garbles data otherwise
  always @(posedge clk) begin
    if (sample_req_r && !sample_valid) begin
      sample_valid      <= 1'b1;
      main_cell_reading <= main_v[sample_ch_r];
      aux_cell_reading  <= aux_v[sample_ch_r];
    end else begin
      sample_valid      <= 1'b0;
      main_cell_reading <= ~main_cell_reading;
      aux_cell_reading  <= ~aux_cell_reading;
    end
    if (sample_valid) nsamp <= nsamp + 1;
  end

  // ====================================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata_r;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    rreg(a, d);
    check(nm, d, exp);
  endtask

  task automatic base();
    for (int i = 0; i < 8; i++) wreg(base_a[i], base_d[i]);
  endtask

  // Clears the flags, then writes the control byte with go
  task automatic launch(input logic [7:0] cmd, input int b);
    logic [7:0] s;
    wreg(8'h01, 8'h1f);
    n0 = nsamp;
    wreg(8'h00, cmd);
    s = 8'h00;
    for (int i = 0; i < 300 && s[b] !== 1'b1; i++) rreg(8'h01, s);
    check("done flag", {15'h0000, s[b]}, 16'h0001);
  endtask

  task automatic apply_chk(input logic [15:0] exp);
    wreg(8'h00, 8'h10);
    @(posedge clk);
    #1 check("fet drive", fet_drive_r, exp);
  endtask

  // ====================================================================
  // Scenarios
  task automatic t_reset();
    rchk(8'h01, 8'h00, "status");
    rchk(8'h13, 8'h80, "aux result hi");
    rchk(8'h14, 8'h00, "aux result lo");
    rchk(8'h10, 8'h10, "cell count");
    rchk(8'h40, 8'h00, "unmapped");
    check("fet drive", fet_drive_r, 16'h0000);
  endtask

  task automatic t_fet();
    base();
    apply_chk(16'h0025);
    launch(8'h0c, 0);
    rchk(8'h04, 8'h04, "fet result lo");
    rchk(8'h05, 8'h00, "fet result hi");
    check("fet samples", 16'(nsamp - n0), 16'd2);
    rchk(8'h00, 8'h04, "ctrl readback");
    wreg(8'h0f, 8'h01);
    launch(8'h0c, 0);
    check("locked samples", 16'(nsamp - n0), 16'd1);
    rchk(8'h15, 8'h10, "diag aux hi");
    rchk(8'h13, 8'h10, "aux result hi");
    wreg(8'h02, 8'h00);
    apply_chk(16'h0000);
    wreg(8'h0c, 8'h81);
    wreg(8'h02, 8'h25);
    wreg(8'h0b, 8'h03);
    apply_chk(16'h0025);
    wreg(8'h0b, 8'h02);
    @(posedge clk);
    #1 check("resumed drive", fet_drive_r, 16'h0081);
  endtask

  task automatic t_abort();
    for (int i = 0; i < 11; i++) begin
      base();
      wreg(bad_a[i], bad_d[i]);
      launch(8'h0c, 4);
      rchk(8'h01, 8'h13, "abort status");
      rchk(8'h04, 8'hff, "abort result lo");
      rchk(8'h05, 8'hff, "abort result hi");
      rchk(8'h13, 8'h80, "abort aux hi");
      check("abort samples", 16'(nsamp - n0), 16'd0);
    end
  endtask

  task automatic t_open_wire();
    base();
    wreg(8'h0a, 8'h30);
    launch(8'h2a, 2);
    check("sense sinks", sense_sink_en_r, 16'hffff);
    rchk(8'h06, 8'h0a, "sense result lo");
    rchk(8'h07, 8'h00, "sense result hi");
    check("sense samples", 16'(nsamp - n0), 16'd4);
    rchk(8'h17, 8'h00, "diag main hi");
    launch(8'h4b, 3);
    check("bottom source", {15'h0000, balance_source_en_r}, 16'h0001);
    rchk(8'h08, 8'h01, "balance result lo");
    check("balance samples", 16'(nsamp - n0), 16'd4);
    rchk(8'h00, 8'h43, "ctrl readback");
    wreg(8'h00, 8'h00);
    @(posedge clk);
    #1 check("balance sinks", balance_sink_en_r, 16'h0000);
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #(20 * 60000);
    mismatches++;
    wrap_up();
  end

  initial begin
    for (int i = 0; i < 16; i++) begin
      main_v[i] = (i == 1) ? 16'h2000 : (i == 3) ? 16'h1000 : 16'h4000;
      aux_v[i]  = (i == 0) ? 16'h1000 : (i == 2) ? 16'h3000 : 16'h5000;
    end
    rstn = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    sample_valid = 1'b0;
    main_cell_reading = 16'h0000;
    aux_cell_reading = 16'h0000;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_fet();
    t_abort();
    t_open_wire();
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
